// ==== hdl/brake_delay_and_gear_params.sv ====
`timescale 1ns/1ns

module brake_delay_and_gear_params
    import brake_gear_pkg::*;
#(
    parameter int ms_ticks = tick_cycles
) (
    input  wire logic        clk,                   // 250 MHz clock
    input  wire logic        rst,                   // Async reset, active high
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB enable
    input  wire logic        pwrite,                // APB direction
    input  wire logic [11:0] paddr,                 // APB byte address
    input  wire logic [31:0] pwdata,                // APB write data
    output logic             pready,                // APB ready
    output logic [31:0]      prdata,                // APB read data
    output logic             pslverr,               // APB error
    input  wire logic        servo_on,              // Servo enable, from drive logic
    input  wire logic        fault_stop,            // Off caused by fault (not excluded one)
    input  wire logic        emergency_stop_input,  // Emergency stop pin
    input  wire logic [15:0] motor_speed,           // Absolute speed, r/min
    input  wire logic [15:0] analog_in_mv,          // Analog input, millivolts
    input  wire logic [31:0] pulse_in,              // Input pulse count
    output logic             brake_release_output,  // High releases brake
    output logic             zero_speed_output,     // Motor at zero speed
    output logic [15:0]      torque_command,        // 0.1 % units, torque mode
    output logic [15:0]      torque_limit,          // 0.1 % units, other modes
    output logic [63:0]      position_command,      // Pulses times gear ratio
    output logic             gear_ratio_ok          // Ratio within legal span
);
    // ************************************************************
    // Input synchroniser for the emergency stop pin
    // ************************************************************
    logic        estop_s1_q;
    logic        estop_s2_q;

    // Only the second stage feeds logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            estop_s1_q <= 1'b0;
            estop_s2_q <= 1'b0;
        end else begin
            estop_s1_q <= emergency_stop_input;
            estop_s2_q <= estop_s1_q;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0] torque_scale_q;
    logic [15:0] brake_on_delay_q;
    logic [15:0] brake_off_delay_q;
    logic [15:0] zero_speed_q;
    logic [31:0] gear_den_q;
    logic [31:0] gear_num_q [0:n_extra_num];
    logic [1:0]  gear_sel_q;
    mode_e       mode_q;
    logic        reject_q;

    // Decode helper, used by write and read paths
    // Registers sit on word boundaries: byte address is four times the index
    function automatic logic hit(input logic [11:0] a, input logic [11:0] idx);
        return a == {idx[9:0], 2'b00};
    endfunction

    wire         wr_en    = psel & penable & pwrite;
    wire         rd_en    = psel & ~pwrite;
    // Extra slots every fourth index from their base
    wire [11:0]  num_base = gear_num_extra_idx - 12'h004;
    // Numerator locked only in register mode while enabled
    wire         num_lock = (mode_q == mode_register) & servo_on;
    // Denominator frozen while enabled in both position modes
    wire         den_lock = ((mode_q == mode_pulse_train) | (mode_q == mode_register)) & servo_on;
    // Out-of-range values dropped without an error
    wire         in_range_num = (pwdata != 32'h0000_0000) && (pwdata <= gear_num_max);
    wire         in_range_den = (pwdata != 32'h0000_0000) && (pwdata <= gear_den_max);

    // Number of slots: first numerator plus extras, one word each
    logic [n_extra_num:0] num_hit;
    genvar gi;
    generate
        for (gi = 0; gi <= n_extra_num; gi++) begin : g_num
            wire [11:0] slot = (gi == 0) ? gear_num_first_idx
                                         : 12'(num_base + 12'(4 * gi));
            assign num_hit[gi] = hit(paddr, slot);

            // Numerator slot storage, all share one denominator
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    gear_num_q[gi] <= gear_num_rst;
                end else if (wr_en && num_hit[gi] && !num_lock && in_range_num) begin
                    gear_num_q[gi] <= pwdata;
                end
            end
        end
    endgenerate

    wire mapped = hit(paddr, torque_scale_idx) | hit(paddr, brake_on_delay_idx)
                | hit(paddr, brake_off_delay_idx) | hit(paddr, gear_den_idx)
                | hit(paddr, zero_speed_idx) | hit(paddr, control_idx)
                | hit(paddr, status_idx) | (|num_hit);

    // Writes of scalar registers; out-of-range values ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            torque_scale_q    <= torque_scale_rst;
            brake_on_delay_q  <= brake_on_delay_rst;
            brake_off_delay_q <= brake_off_delay_rst;
            zero_speed_q      <= zero_speed_rst;
            gear_den_q        <= gear_den_rst;
            gear_sel_q        <= 2'h0;
            mode_q            <= mode_pulse_train;
        end else if (wr_en) begin
            if (hit(paddr, torque_scale_idx) && pwdata[15:0] <= torque_scale_max) begin
                torque_scale_q <= pwdata[15:0];
            end

            if (hit(paddr, brake_on_delay_idx) && pwdata[15:0] <= torque_scale_max) begin
                brake_on_delay_q <= pwdata[15:0];
            end

            if (hit(paddr, brake_off_delay_idx)
                && ($signed(pwdata[15:0]) <= $signed(torque_scale_max))
                && ($signed(pwdata[15:0]) >= -$signed(torque_scale_max))) begin
                brake_off_delay_q <= pwdata[15:0];
            end

            if (hit(paddr, zero_speed_idx)) begin
                zero_speed_q <= pwdata[15:0];
            end

            if (hit(paddr, gear_den_idx) && !den_lock && in_range_den) begin
                gear_den_q <= pwdata;
            end

            if (hit(paddr, control_idx)) begin
                gear_sel_q <= pwdata[ctl_gear_sel_lo +: 2];
                mode_q     <= mode_e'(pwdata[ctl_mode_lo +: 2]);
            end
        end
    end

    // Sticky flag: numerator write refused while locked; set wins
    wire reject_set = wr_en & (|num_hit) & num_lock;
    wire reject_clr = wr_en & hit(paddr, status_idx) & pwdata[0];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reject_q <= 1'b0;
        end else begin
            reject_q <= reject_set | (reject_q & ~reject_clr);
        end
    end

    // Read mux, registered data
    wire [31:0] status_word = {26'h0, gear_ratio_ok, zero_speed_output,
                               brake_release_output, servo_on, 1'b0, reject_q};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i <= n_extra_num; i++) begin
            if (num_hit[i]) begin
                rd_mux = gear_num_q[i];
            end
        end
        if (hit(paddr, torque_scale_idx)) begin
            rd_mux = {16'h0, torque_scale_q};
        end
        if (hit(paddr, brake_on_delay_idx)) begin
            rd_mux = {16'h0, brake_on_delay_q};
        end
        if (hit(paddr, brake_off_delay_idx)) begin
            rd_mux = {16'h0, brake_off_delay_q};
        end
        if (hit(paddr, zero_speed_idx)) begin
            rd_mux = {16'h0, zero_speed_q};
        end
        if (hit(paddr, gear_den_idx)) begin
            rd_mux = gear_den_q;
        end
        if (hit(paddr, control_idx)) begin
            rd_mux = {26'h0, mode_q, 2'h0, gear_sel_q};
        end
        if (hit(paddr, status_idx)) begin
            rd_mux = status_word;
        end
    end

    // Read data caught in setup phase so access phase completes in one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            prdata <= rd_mux;
        end
    end

    // Zero wait states in the access phase
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ************************************************************
    // Torque scaling
    // ************************************************************
    // Tenths of a percent: mV times setting times ten over full-scale mV
    wire [31:0] torque_raw = (32'(analog_in_mv) * 32'(torque_scale_q) * volts_div)
                           / 32'(ain_full_mv);
    // Ceiling of the range, in the same tenths
    wire [31:0] torque_max = 32'(torque_scale_max) * volts_div;
    wire [15:0] torque_sat = (torque_raw > torque_max) ? 16'(torque_max)
                                                       : torque_raw[15:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            torque_command <= 16'h0000;
            torque_limit   <= 16'h0000;
        end else if (mode_q == mode_torque) begin
            torque_command <= torque_sat;
            torque_limit   <= 16'h0000;
        end else begin
            torque_command <= 16'h0000;
            torque_limit   <= torque_sat;
        end
    end

    // ************************************************************
    // Zero speed and brake sequencing
    // ************************************************************
    // Zero speed also allows an early engage
    wire at_zero = (motor_speed <= zero_speed_q);

    // One enable per millisecond for both delays
    logic tick;
    ms_tick #(.ticks(ms_ticks)) u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    // Brake sequencing states
    typedef enum logic [1:0] {st_held, st_on_wait, st_released, st_off_wait} brake_e;
    brake_e      st_q;
    logic        servo_q;
    logic [15:0] ms_q;

    // Servo edges against last cycle's level
    wire         servo_rise = servo_on & ~servo_q;
    wire         servo_fall = ~servo_on & servo_q;
    wire         neg_off    = brake_off_delay_q[15];
    // Forced stops ignore a negative delay
    wire         forced     = fault_stop | estop_s2_q;
    wire [15:0]  off_mag    = neg_off ? 16'(-brake_off_delay_q) : brake_off_delay_q;
    wire         off_now    = neg_off & forced;
    // Past the count: tick phase is free, so equality may be a ms early
    wire         on_done    = (brake_on_delay_q == 16'h0000) | (ms_q > brake_on_delay_q);
    wire         off_done   = off_now | (off_mag == 16'h0000) | (ms_q > off_mag);

    // Counter restarts on each servo edge, advances on ms tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            servo_q <= 1'b0;
            ms_q    <= 16'h0000;
        end else begin
            servo_q <= servo_on;
            if (servo_rise || servo_fall) begin
                ms_q <= 16'h0000;
            end else if (tick && ms_q != 16'hFFFF) begin
                ms_q <= ms_q + 16'h0001;
            end
        end
    end

    // Brake state; a negative off delay is treated by magnitude here, or as zero under a forced stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= st_held;
        end else begin
            unique case (st_q)
                st_held: begin
                    if (servo_on) st_q <= st_on_wait;
                end

                st_on_wait: begin
                    if (!servo_on)    st_q <= st_held;
                    else if (on_done) st_q <= st_released;
                end

                st_released: begin
                    if (!servo_on) st_q <= st_off_wait;
                end

                st_off_wait: begin
                    if (servo_on)               st_q <= st_on_wait;
                    else if (at_zero)           st_q <= st_held;
                    else if (off_done)          st_q <= st_held;
                end
            endcase
        end
    end

    // Brake stays released through the off wait
    assign brake_release_output = (st_q == st_released) | (st_q == st_off_wait);
    assign zero_speed_output    = at_zero;

    // ************************************************************
    // Electronic gear
    // ************************************************************
    // Selected numerator over the one denominator
    wire [31:0] num_sel = gear_num_q[gear_sel_q];
    // N/M < 25600 and N/M > 1/50, checked without division
    wire [63:0] n_ext   = 64'(num_sel);
    wire [63:0] m_ext   = 64'(gear_den_q);
    assign gear_ratio_ok = (n_ext < m_ext * 64'(ratio_hi))
                         & (n_ext * 64'(ratio_lo_div) > m_ext);

    // Registered quotient; pulses times numerator, divided by the denominator here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            position_command <= 64'h0;
        end else if (gear_ratio_ok) begin
            position_command <= (64'(pulse_in) * n_ext) / m_ext;
        end
    end
endmodule // brake_delay_and_gear_params

// ==== hdl/brake_gear_pkg.sv ====
package brake_gear_pkg;

    // ************************************************************
    // Register map: word index, byte address is four times it
    // ************************************************************
    localparam logic [11:0] torque_scale_idx     = 12'h152;
    localparam logic [11:0] brake_on_delay_idx   = 12'h154;
    localparam logic [11:0] brake_off_delay_idx  = 12'h156;
    localparam logic [11:0] gear_num_first_idx   = 12'h158;
    localparam logic [11:0] gear_den_idx         = 12'h15A;
    localparam logic [11:0] zero_speed_idx       = 12'h14C;
    localparam logic [11:0] gear_num_extra_idx   = 12'h1C0;
    localparam logic [11:0] control_idx          = 12'h1D0;
    localparam logic [11:0] status_idx           = 12'h1D4;

    // ************************************************************
    // Reset values and limits
    // ************************************************************
    localparam logic [15:0] torque_scale_rst     = 16'h0064;
    localparam logic [15:0] brake_on_delay_rst   = 16'h0000;
    localparam logic [15:0] brake_off_delay_rst  = 16'h0000;
    localparam logic [31:0] gear_num_rst         = 32'h0000_0080;
    localparam logic [31:0] gear_den_rst         = 32'h0000_000A;
    localparam logic [15:0] zero_speed_rst       = 16'h0064;
    localparam logic [15:0] torque_scale_max     = 16'h03E8;
    localparam logic [31:0] gear_num_max         = 32'h1FFF_FFFF;
    localparam logic [31:0] gear_den_max         = 32'h7FFF_FFFF;
    localparam logic [31:0] ratio_hi             = 32'h0000_6400;
    localparam logic [31:0] ratio_lo_div         = 32'h0000_0032;
    localparam int          n_extra_num          = 3;

    // ************************************************************
    // Analog scaling: input in millivolts, result in 0.1 percent
    // ************************************************************
    localparam logic [15:0] ain_full_mv          = 16'h2710;
    localparam logic [31:0] volts_div            = 32'h0000_000A;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          clk_mhz              = 250;
    localparam int          tick_us              = 1000;
    localparam int          tick_cycles          = clk_mhz * tick_us;

    // Control register bit positions
    localparam int          ctl_gear_sel_lo      = 0;
    localparam int          ctl_mode_lo          = 4;

    typedef enum logic [1:0] {mode_pulse_train, mode_register, mode_speed, mode_torque} mode_e;

endpackage

// ==== hdl/ms_tick.sv ====
`timescale 1ns/1ns
// ************************************************************
// Millisecond enable divider
// ************************************************************
module ms_tick
    import brake_gear_pkg::*;
#(
    parameter int ticks = tick_cycles
) (
    input  wire logic clk,   // System clock
    input  wire logic rst,   // Async reset
    output logic      tick   // One-cycle pulse per ms
);
    logic [31:0] cnt_q;

    // Free-running count, pulse at wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0000_0000;
        end else if (cnt_q == 32'(ticks - 1)) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    assign tick = (cnt_q == 32'(ticks - 1));
endmodule // ms_tick

// ==== testbench/brake_gear_sva.sv ====
`timescale 1ns/1ns
// ************************************************************
// Port checker
// ************************************************************
module brake_gear_sva
    import brake_gear_pkg::*;
#(
    parameter int ms_ticks = tick_cycles
) (
    input wire logic        clk,                  // Clock
    input wire logic        rst,                  // Async reset
    input wire logic        psel,                 // APB select
    input wire logic        penable,              // APB enable
    input wire logic        pready,               // APB ready
    input wire logic        pslverr,              // APB error
    input wire logic        servo_on,             // Servo enable
    input wire logic [15:0] motor_speed,          // Speed
    input wire logic        brake_release_output, // Brake released
    input wire logic        zero_speed_output,    // Zero speed flag
    input wire logic [15:0] torque_command,       // Torque command
    input wire logic [15:0] torque_limit,         // Torque limit
    input wire logic [63:0] position_command,     // Scaled position
    input wire logic        gear_ratio_ok         // Ratio legal
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Longest legal off delay plus tick slack
    localparam int off_lim = 1002 * ms_ticks + 8;
    int unsigned off_cnt_q;

    // Cycles released with servo off; a stuck release shows up here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            off_cnt_q <= 0;
        end else if (!servo_on && brake_release_output) begin
            off_cnt_q <= off_cnt_q + 1;
        end else begin
            off_cnt_q <= 0;
        end
    end

    sequence off_at_rest;
        !servo_on && zero_speed_output;
    endsequence

    ready_zero_wait_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    err_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    // Bench leaves the zero range at its reset value
    zero_speed_flag_a: assert property (zero_speed_output == (motor_speed <= zero_speed_rst))
        else $error("zero speed flag wrong");
    release_after_on_a: assert property ($rose(brake_release_output) |-> $past(servo_on))
        else $error("brake released without servo on");
    rest_engage_a: assert property (off_at_rest |-> ##[0:3] !brake_release_output)
        else $error("brake not engaged at rest");
    off_delay_bound_a: assert property (off_cnt_q < off_lim)
        else $error("brake held released too long");
    torque_one_out_a: assert property (!(torque_command != 0 && torque_limit != 0))
        else $error("command and limit both nonzero");
    torque_sat_a: assert property (torque_command <= 16'h2710 && torque_limit <= 16'h2710)
        else $error("torque above range");
    pos_hold_a: assert property (!gear_ratio_ok |=> $stable(position_command))
        else $error("position moved with bad ratio");
endmodule // brake_gear_sva

bind brake_delay_and_gear_params brake_gear_sva #(.ms_ticks(ms_ticks)) i_brake_gear_sva (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .servo_on(servo_on), .motor_speed(motor_speed),
    .brake_release_output(brake_release_output), .zero_speed_output(zero_speed_output),
    .torque_command(torque_command), .torque_limit(torque_limit),
    .position_command(position_command), .gear_ratio_ok(gear_ratio_ok));

// ==== testbench/motor_host_model.sv ====
`timescale 1ns/1ns
// ************************************************************
// Motor with holding brake, and pulse source
// ************************************************************
module motor_host_model (
    input  wire logic        clk,                  // Clock
    input  wire logic        rst,                  // Async reset
    input  wire logic        brake_release_output, // Brake released
    input  wire logic [15:0] speed_req,            // Speed the load wants
    input  wire logic [31:0] pulses_req,           // Host pulse count
    output logic      [15:0] motor_speed,          // Measured speed
    output logic      [31:0] pulse_in              // Pulses to drive
);
    // Held brake drags the shaft down; released shaft follows load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            motor_speed <= 16'h0000;
            pulse_in    <= 32'h0000_0000;
        end else begin
            motor_speed <= brake_release_output ? speed_req : motor_speed >> 1;
            pulse_in    <= pulses_req;
        end
    end
endmodule // motor_host_model

// ==== testbench/tb_brake_delay_and_gear_params.sv ====
`timescale 1ns/1ns
module tb_brake_delay_and_gear_params;
    import brake_gear_pkg::*;

    localparam int ms = 10; // Short tick keeps delays cheap
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        servo_on = 0, fault_stop = 0, emergency_stop_input = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat, pulses_req = 32'h0, pulse_in, prdata;
    logic [15:0] analog_in_mv = 16'h0, speed_req = 16'h0, motor_speed;
    logic [15:0] torque_command, torque_limit;
    logic [63:0] position_command;
    logic        rerr, pready, pslverr, brake_release_output;
    logic        zero_speed_output, gear_ratio_ok;
    int          bad_count = 0, n_checks = 0, cyc = 0, n;

    always #2 clk = ~clk;

    brake_delay_and_gear_params #(.ms_ticks(ms)) i_brake_delay_and_gear_params (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .servo_on(servo_on), .fault_stop(fault_stop),
        .emergency_stop_input(emergency_stop_input), .motor_speed(motor_speed),
        .analog_in_mv(analog_in_mv), .pulse_in(pulse_in),
        .brake_release_output(brake_release_output), .zero_speed_output(zero_speed_output),
        .torque_command(torque_command), .torque_limit(torque_limit),
        .position_command(position_command), .gear_ratio_ok(gear_ratio_ok));

    motor_host_model i_motor_host_model (
        .clk(clk), .rst(rst), .brake_release_output(brake_release_output),
        .speed_req(speed_req), .pulses_req(pulses_req), .motor_speed(motor_speed),
        .pulse_in(pulse_in));

    task end_of_test();
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Hang guard, well beyond the longest scenario
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            end_of_test();
        end
    end

    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // One APB transfer to a register index; idle edge after it
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {a[9:0], 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Look mid-cycle, resume on a rising edge
    task wait_brake(input logic lvl);
        n = 0;
        @(negedge clk);
        while (brake_release_output !== lvl && n < 20000) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask

    task t_regs();
        apb(1'b0, brake_off_delay_idx, 32'h0);
        chk("off_delay_rst", rdat, 64'h0);
        apb(1'b0, gear_num_first_idx, 32'h0);
        chk("num_rst", rdat, 64'h80);
        apb(1'b0, gear_den_idx, 32'h0);
        chk("den_rst", rdat, 64'hA);
        apb(1'b0, 12'h0F0, 32'h0);
        chk("unmapped_err", rerr, 64'h1);
    endtask

    task t_torque();
        apb(1'b1, control_idx, 32'h30);
        analog_in_mv <= 16'h1388;
        repeat (4) @(posedge clk);
        chk("tq_cmd_half", torque_command, 64'h1F4);
        chk("tq_lim_off", torque_limit, 64'h0);
        apb(1'b1, control_idx, 32'h20);
        repeat (4) @(posedge clk);
        chk("tq_lim_half", torque_limit, 64'h1F4);
        chk("tq_cmd_off", torque_command, 64'h0);
        apb(1'b1, torque_scale_idx, 32'h3E8);
        analog_in_mv <= 16'hFFFF;
        repeat (4) @(posedge clk);
        chk("tq_lim_sat", torque_limit, 64'h2710);
        analog_in_mv <= 16'h0000;
    endtask

    task t_brake();
        apb(1'b1, brake_on_delay_idx, 32'h3);
        apb(1'b1, brake_off_delay_idx, 32'h2);
        speed_req <= 16'h01F4;
        servo_on  <= 1'b1;
        wait_brake(1'b1);
        chk("on_late_enough", n >= 3 * ms, 64'h1);
        chk("on_soon_enough", n <= 4 * ms + 4, 64'h1);
        repeat (2) @(posedge clk);
        servo_on <= 1'b0;
        wait_brake(1'b0);
        chk("off_late_enough", n >= 2 * ms, 64'h1);
        chk("off_fast_moving", n <= 3 * ms + 4, 64'h1);
        apb(1'b1, brake_off_delay_idx, 32'h1F4);
        servo_on <= 1'b1;
        wait_brake(1'b1);
        speed_req <= 16'h0032;
        repeat (3) @(posedge clk);
        servo_on <= 1'b0;
        wait_brake(1'b0);
        chk("off_at_rest", n <= 4, 64'h1);
        // Negative delay under fault, then under emergency stop
        apb(1'b1, brake_off_delay_idx, 32'hFFFB);
        speed_req <= 16'h01F4;
        for (int k = 0; k < 2; k++) begin
            servo_on <= 1'b1;
            wait_brake(1'b1);
            fault_stop           <= (k == 0);
            emergency_stop_input <= (k == 1);
            repeat (4) @(posedge clk);
            servo_on <= 1'b0;
            wait_brake(1'b0);
            chk("forced_stop_now", n <= 4, 64'h1);
            fault_stop           <= 1'b0;
            emergency_stop_input <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    task t_gear();
        pulses_req <= 32'hA;
        apb(1'b1, control_idx, 32'h00);
        servo_on <= 1'b1;
        apb(1'b1, gear_num_first_idx, 32'h200);
        apb(1'b0, gear_num_first_idx, 32'h0);
        chk("num_live_train", rdat, 64'h200);
        apb(1'b1, control_idx, 32'h10);
        apb(1'b1, gear_num_first_idx, 32'h300);
        apb(1'b0, gear_num_first_idx, 32'h0);
        chk("num_locked_reg", rdat, 64'h200);
        apb(1'b0, status_idx, 32'h0);
        chk("reject_flag", rdat[0], 64'h1);
        servo_on <= 1'b0;
        apb(1'b1, gear_num_first_idx, 32'h300);
        apb(1'b1, gear_num_first_idx, 32'h0);
        apb(1'b1, gear_num_first_idx, 32'h2000_0000);
        apb(1'b0, gear_num_first_idx, 32'h0);
        chk("num_range", rdat, 64'h300);
        apb(1'b1, gear_den_idx, 32'h8000_0000);
        apb(1'b0, gear_den_idx, 32'h0);
        chk("den_range", rdat, 64'hA);
        chk("pos_first", position_command, 64'h300);
        apb(1'b1, gear_num_extra_idx, 32'h3E8);
        apb(1'b1, control_idx, 32'h11);
        repeat (4) @(posedge clk);
        chk("pos_extra", position_command, 64'h3E8);
        // Ratio exactly one fiftieth is outside the open span
        apb(1'b1, gear_den_idx, 32'hC350);
        repeat (2) @(posedge clk);
        chk("ratio_edge", gear_ratio_ok, 64'h0);
        apb(1'b1, gear_den_idx, 32'hC34F);
        repeat (2) @(posedge clk);
        chk("ratio_inside", gear_ratio_ok, 64'h1);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_torque();
        t_brake();
        t_gear();
        end_of_test();
    end
endmodule // tb_brake_delay_and_gear_params
